// ---- logic/two_wire_consts.vh ----
// constants for the two-wire bus slave engine
// assumes a single 50 MHz clock and an 8-bit register port
// Summary of operation
// [RL1] slave only, never generates START
// [RL2] START sets the bus busy flag
// [RL3] START is data falling while clock high
// [RL4] first byte's top seven bits compared with ours
// [RL5] address equal: match flag and interrupt request
// [RL6] eighth bit lands in master read request
// [RL7] matched address acknowledged low on ninth clock
// [RL8] one interrupt; match flag tells sources apart
// [RL9] clock held low until software services data
// [RL10] transmit mode select: 1 sends, 0 receives
// [RL11] master sends STOP after unanswered address
// [RL12] bytes are eight bits, MSB first
// [RL13] receiver answers each byte with low acknowledge; data bytes get the ack_to_send bit, which may be high
// [RL14] unanswered transmitter releases data; master STOPs
// [RL15] receiving, ack_to_send driven on ninth clock
// [RL16] transmitting, record master acknowledge; stop on none
// [RL17] every byte passes through the data register; the address byte never reaches data_reg
// [RL18] STOP clears the bus busy flag
// [RL19] byte done low during transfer, high after
// [RL20] own address sits in bits 7 to 1
// [RL21] clock and data synchronised, edges detected
`ifndef TWO_WIRE_CONSTS_VH
`define TWO_WIRE_CONSTS_VH

// register offsets
`define OFF_CTRL_B 2'h1
`define OFF_DATA 2'h2
`define OFF_OWN_ADDR 2'h3

// serial_ctrl_reg_b bit positions
`define BIT_BYTE_DONE 7
`define BIT_ADDR_MATCH 6
`define BIT_BUS_BUSY 5
`define BIT_TX_MODE 4
`define BIT_ACK_TO_SEND 3
`define BIT_MASTER_READ 2
`define BIT_ACK_RECEIVED 0

// reset values
`define RST_DATA 8'h00
`define RST_OWN_ADDR 8'h00
`define RST_BYTE_DONE 1'b1
`define RST_ACK_TO_SEND 1'b0
`define RST_TX_MODE 1'b0

// bit counts
`define BITS_PER_BYTE 4'h8

`endif

// ---- logic/two_wire_bus_slave_engine.v ----
// two-wire bus slave engine: address match, byte transfer, clock stretch
// assumes open-drain pins resolved outside; pins are asynchronous to
// ref_clk_i, which must run well above the bus clock rate
`include "two_wire_consts.vh"

module two_wire_bus_slave_engine (
	// clock and reset
	input wire ref_clk_i,
	input wire arst_n_i,
	// register port
	input wire [1:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [7:0] reg_rdata_o,
	// bus clock line, open drain
	input wire scl_i,
	output reg scl_o,
	output reg scl_oe_n_o,
	// bus data line, open drain
	input wire sda_i,
	output reg sda_o,
	output reg sda_oe_n_o,
	// request to the interrupt controller
	output reg irq_o
);

	localparam [3:0] ST_IDLE = 4'h0;
	localparam [3:0] ST_ADDR = 4'h1;
	localparam [3:0] ST_ACK_ADDR = 4'h2;
	localparam [3:0] ST_STRETCH = 4'h3;
	localparam [3:0] ST_RX = 4'h4;
	localparam [3:0] ST_ACK_RX = 4'h5;
	localparam [3:0] ST_TX = 4'h6;
	localparam [3:0] ST_ACK_TX = 4'h7;
	localparam [3:0] ST_WAIT_STOP = 4'h8;

	// synchronisers; only stage two and later are read by logic
	reg scl_s1_reg;
	reg scl_s2_reg;
	reg scl_s3_reg;
	reg sda_s1_reg;
	reg sda_s2_reg;
	reg sda_s3_reg;

	// software visible state
	reg [7:0] data_reg;
	reg [7:0] own_addr_reg;
	reg tx_mode_reg;
	reg ack_to_send_reg;
	reg byte_done_reg;
	reg addr_match_reg;
	reg bus_busy_reg;
	reg master_read_reg;
	reg ack_received_reg;

	// engine state
	reg [3:0] state_reg;
	reg [3:0] bit_cnt_reg;
	reg [7:0] shift_reg;

	wire scl_rise;
	wire scl_fall;
	wire start_seen;
	wire stop_seen;
	wire data_wr;
	wire data_rd;
	wire sw_service;
	wire byte_full;
	wire [7:0] status_word;

	// register index decode, shared by strobes and the write path
	function hit;
		input [1:0] addr;
		input [1:0] offset;
		begin
			hit = (addr == offset);
		end
	endfunction

	// one bus bit into the bottom of a byte; MSB arrives first
	function [7:0] shift_in;
		input [7:0] byte_in;
		input bit_in;
		begin
			shift_in = {byte_in[6:0], bit_in};
		end
	endfunction

	// clock fall that closes an eight bit byte
	function byte_end;
		input fall;
		input full;
		begin
			byte_end = fall & full;
		end
	endfunction

	// edge between two settled stages; up picks the direction
	function edge_of;
		input now_lvl;
		input was_lvl;
		input up;
		begin
			edge_of = up ? (now_lvl & ~was_lvl) : (~now_lvl & was_lvl);
		end
	endfunction

	always @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			scl_s1_reg <= 1'b1;
			scl_s2_reg <= 1'b1;
			scl_s3_reg <= 1'b1;
			sda_s1_reg <= 1'b1;
			sda_s2_reg <= 1'b1;
			sda_s3_reg <= 1'b1;
		end else begin
			scl_s1_reg <= scl_i; // RL21
			scl_s2_reg <= scl_s1_reg;
			scl_s3_reg <= scl_s2_reg;
			sda_s1_reg <= sda_i; // RL21
			sda_s2_reg <= sda_s1_reg;
			sda_s3_reg <= sda_s2_reg;
		end
	end

	// edges judged on the settled stages, never on the first flop
	assign scl_rise = edge_of(scl_s2_reg, scl_s3_reg, 1'b1); // RL21
	assign scl_fall = edge_of(scl_s2_reg, scl_s3_reg, 1'b0); // RL21
	assign start_seen = scl_s2_reg & scl_s3_reg &
		~sda_s2_reg & sda_s3_reg; // RL3
	assign stop_seen = scl_s2_reg & scl_s3_reg &
		sda_s2_reg & ~sda_s3_reg;

	assign data_wr = reg_wr_i & hit(reg_addr_i, `OFF_DATA);
	assign data_rd = reg_rd_i & hit(reg_addr_i, `OFF_DATA);
	// transmit wants a fresh byte, receive a dummy or real read
	assign sw_service = tx_mode_reg ? data_wr : data_rd; // RL9
	assign byte_full = (bit_cnt_reg == `BITS_PER_BYTE);
	// status byte as software reads it; bit 1 carries nothing
	assign status_word = {byte_done_reg, addr_match_reg, bus_busy_reg,
		tx_mode_reg, ack_to_send_reg, master_read_reg, 1'b0,
		ack_received_reg};

	// software writes; engine owns the status bits
	always @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			own_addr_reg <= `RST_OWN_ADDR;
			tx_mode_reg <= `RST_TX_MODE;
			ack_to_send_reg <= `RST_ACK_TO_SEND;
		end else if (reg_wr_i) begin
			if (hit(reg_addr_i, `OFF_OWN_ADDR)) begin
				own_addr_reg <= reg_wdata_i;
			end
			if (hit(reg_addr_i, `OFF_CTRL_B)) begin
				tx_mode_reg <= reg_wdata_i[`BIT_TX_MODE]; // RL10
				ack_to_send_reg <= reg_wdata_i[`BIT_ACK_TO_SEND];
			end
		end
	end

	// register read, data one cycle after the strobe
	always @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				`OFF_CTRL_B: begin
					reg_rdata_o <= status_word;
				end
				`OFF_DATA: begin
					reg_rdata_o <= data_reg; // RL17
				end
				`OFF_OWN_ADDR: begin
					// bit 0 carries nothing
					reg_rdata_o <= {own_addr_reg[7:1], 1'b0}; // RL20
				end
				default: begin
					reg_rdata_o <= 8'h00;
				end
			endcase
		end else begin
			reg_rdata_o <= 8'h00;
		end
	end

	// bus engine; the engine never drives a START of its own
	always @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_reg <= ST_IDLE;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			data_reg <= `RST_DATA;
			byte_done_reg <= `RST_BYTE_DONE;
			addr_match_reg <= 1'b0;
			bus_busy_reg <= 1'b0;
			master_read_reg <= 1'b0;
			ack_received_reg <= 1'b0;
			scl_o <= 1'b0;
			sda_o <= 1'b0;
			scl_oe_n_o <= 1'b1;
			sda_oe_n_o <= 1'b1;
			irq_o <= 1'b0;
		end else begin
			irq_o <= 1'b0;
			// a data write outside a byte hand-off just stores the byte
			if (data_wr && state_reg != ST_STRETCH) begin
				data_reg <= reg_wdata_i; // RL17
			end
			if (start_seen) begin
				// repeated START also lands here and restarts cleanly
				bus_busy_reg <= 1'b1; // RL2
				addr_match_reg <= 1'b0;
				state_reg <= ST_ADDR; // RL4
				bit_cnt_reg <= 4'h0;
				scl_oe_n_o <= 1'b1;
				// a START is only watched here, never made
				sda_oe_n_o <= 1'b1; // RL1
			end else if (stop_seen) begin
				// a cut frame must not leave a stretch behind
				bus_busy_reg <= 1'b0; // RL18
				state_reg <= ST_IDLE;
				scl_oe_n_o <= 1'b1;
				sda_oe_n_o <= 1'b1;
			end else begin
				case (state_reg)
					ST_IDLE: begin
						scl_oe_n_o <= 1'b1;
						sda_oe_n_o <= 1'b1;
					end
					ST_ADDR: begin
						if (scl_rise) begin
							shift_reg <= shift_in(shift_reg, sda_s2_reg); // RL12
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end else if (byte_end(scl_fall, byte_full)) begin
							if (shift_reg[7:1] == own_addr_reg[7:1]) begin // RL4
								master_read_reg <= shift_reg[0]; // RL6
								addr_match_reg <= 1'b1; // RL5
								irq_o <= 1'b1; // RL8
								sda_oe_n_o <= 1'b0; // RL7
								state_reg <= ST_ACK_ADDR;
							end else begin
								// not ours: stay off the wires till STOP
								state_reg <= ST_WAIT_STOP; // RL11
							end
						end
					end
					ST_ACK_ADDR: begin
						if (scl_fall) begin
							sda_oe_n_o <= 1'b1;
							scl_oe_n_o <= 1'b0; // RL9
							state_reg <= ST_STRETCH;
						end
					end
					ST_STRETCH: begin
						scl_oe_n_o <= 1'b0; // RL9
						if (sw_service) begin
							bit_cnt_reg <= 4'h0;
							byte_done_reg <= 1'b0; // RL19
							scl_oe_n_o <= 1'b1;
							if (tx_mode_reg) begin
								// first bit goes out while the clock is low
								data_reg <= reg_wdata_i; // RL17
								shift_reg <= reg_wdata_i;
								sda_oe_n_o <= reg_wdata_i[7]; // RL12
								state_reg <= ST_TX; // RL10
							end else begin
								sda_oe_n_o <= 1'b1;
								state_reg <= ST_RX; // RL10
							end
						end
					end
					ST_RX: begin
						if (scl_rise) begin
							shift_reg <= shift_in(shift_reg, sda_s2_reg); // RL12
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end else if (byte_end(scl_fall, byte_full)) begin
							data_reg <= shift_reg; // RL17
							byte_done_reg <= 1'b1; // RL19
							addr_match_reg <= 1'b0; // RL8
							irq_o <= 1'b1; // RL19
							// 0 acknowledges, 1 declines the next byte
							sda_oe_n_o <= ack_to_send_reg; // RL15
							state_reg <= ST_ACK_RX; // RL13
						end
					end
					ST_ACK_RX: begin
						if (scl_fall) begin
							sda_oe_n_o <= 1'b1;
							scl_oe_n_o <= 1'b0; // RL9
							state_reg <= ST_STRETCH;
						end
					end
					ST_TX: begin
						if (scl_rise) begin
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end else if (scl_fall) begin
							if (byte_full) begin
								// let the master drive its acknowledge
								sda_oe_n_o <= 1'b1;
								state_reg <= ST_ACK_TX;
							end else begin
								shift_reg <= shift_in(shift_reg, 1'b0);
								sda_oe_n_o <= shift_reg[6]; // RL12
							end
						end
					end
					ST_ACK_TX: begin
						if (scl_rise) begin
							ack_received_reg <= sda_s2_reg; // RL16
							byte_done_reg <= 1'b1; // RL19
							addr_match_reg <= 1'b0; // RL8
							irq_o <= 1'b1; // RL19
						end else if (scl_fall) begin
							if (!ack_received_reg) begin
								scl_oe_n_o <= 1'b0; // RL9
								state_reg <= ST_STRETCH;
							end else begin
								// no acknowledge: hands off, master ends it
								sda_oe_n_o <= 1'b1; // RL14
								state_reg <= ST_WAIT_STOP; // RL16
							end
						end
					end
					ST_WAIT_STOP: begin
						scl_oe_n_o <= 1'b1;
						sda_oe_n_o <= 1'b1; // RL16
					end
					default: begin
						state_reg <= ST_IDLE;
						scl_oe_n_o <= 1'b1;
						sda_oe_n_o <= 1'b1;
					end
				endcase
			end
		end
	end

endmodule

// ---- dv/two_wire_bus_slave_engine_properties.sv ----
// checker: line and register port relations
// sees only the engine's ports
`include "two_wire_consts.vh"
module tw_props (
	input wire ref_clk_i,
	input wire arst_n_i,
	input wire [1:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	input wire [7:0] reg_rdata_o,
	input wire scl_i,
	input wire scl_o,
	input wire scl_oe_n_o,
	input wire sda_i,
	input wire sda_o,
	input wire sda_oe_n_o,
	input wire irq_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i);
	reg tx_reg;
	// data access that ends a stretch in the current mode
	wire svc = reg_addr_i == `OFF_DATA && (tx_reg ? reg_wr_i : reg_rd_i);
	always @(posedge ref_clk_i or negedge arst_n_i)
		if (!arst_n_i)
			tx_reg <= 1'b0;
		else if (reg_wr_i && reg_addr_i == `OFF_CTRL_B)
			tx_reg <= reg_wdata_i[`BIT_TX_MODE];
	sequence svc_s;
		!scl_oe_n_o && svc;
	endsequence
	AST_NO_START: assert property ($fell(sda_oe_n_o) |-> !scl_i)
		else $error("data pulled with clock high");
	AST_SDA_FREE: assert property ($rose(sda_oe_n_o) |-> !scl_i)
		else $error("data freed with clock high");
	AST_OPEN_DRAIN: assert property (!scl_o && !sda_o)
		else $error("line driven high");
	AST_STRETCH_LOW: assert property ($fell(scl_oe_n_o) |-> !scl_i)
		else $error("stretch on high clock");
	AST_STRETCH_HOLD: assert property (!scl_oe_n_o && !svc
		&& !$past(svc) |=> !scl_oe_n_o) else $error("stretch lost");
	AST_STRETCH_REL: assert property (svc_s |-> ##[1:2] scl_oe_n_o)
		else $error("stretch not freed");
	AST_IRQ_PULSE: assert property (irq_o |=> !irq_o)
		else $error("long irq");
	AST_RDATA_IDLE: assert property (!$past(reg_rd_i) |-> !reg_rdata_o)
		else $error("read data not idle");
endmodule
bind two_wire_bus_slave_engine tw_props tw_props_inst (.*);

// ---- dv/tw_master.sv ----
// partner: bus master on open-drain lines
// lines are wired-and with pull-ups in the bench
module tw_master (
	input wire scl_w,
	input wire sda_w,
	output logic scl_m = 1'b1,
	output logic sda_m = 1'b1
);
	timeunit 1ns;
	timeprecision 1ns;
	task start;
		#3 sda_m = 1'b0;
		#80 scl_m = 1'b0;
		#80;
	endtask
	task stop;
		#3 sda_m = 1'b0;
		#40 scl_m = 1'b1;
		#80 sda_m = 1'b1;
		#80;
	endtask
	task bitx(input logic b, output logic r);
		int n;
		sda_m = b;
		#40 scl_m = 1'b1;
		// slave may stretch: wait bounded
		for (n = 0; n < 500 && !scl_w; n++) #10;
		#40 r = sda_w;
		#40 scl_m = 1'b0;
		#40;
	endtask
	task xb(input logic [7:0] d, input logic a, output logic [7:0] q,
		output logic k);
		int i;
		logic r;
		#3;
		for (i = 7; i >= 0; i--) begin
			bitx(d[i], r);
			q = {q[6:0], r};
		end
		bitx(a, k);
	endtask
endmodule

// ---- dv/two_wire_bus_slave_engine_test.sv ----
// bench: register port driver and scenarios
// master model on the lines, checker bound to engine
module two_wire_bus_slave_engine_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic [1:0] reg_addr_i = 2'h0;
	logic [7:0] reg_wdata_i = 8'h00;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	wire [7:0] reg_rdata_o;
	wire scl_o, scl_oe_n_o, sda_o, sda_oe_n_o, irq_o, scl_m, sda_m;
	// pull-ups: a released line reads high
	wire scl_i = scl_m & (scl_oe_n_o | scl_o);
	wire sda_i = sda_m & (sda_oe_n_o | sda_o);
	int error_cnt = 0;
	int tests_run = 0;
	int irqs = 0;
	logic [7:0] q;
	logic k;
	two_wire_bus_slave_engine two_wire_bus_slave_engine_inst (.*);
	tw_master tw_master_inst (.scl_w(scl_i), .sda_w(sda_i),
		.scl_m(scl_m), .sda_m(sda_m));
	initial forever #10 ref_clk_i = ~ref_clk_i;
	// counted on the falling edge, between launching edges, so each pulse is seen once
	always @(negedge ref_clk_i) if (irq_o) irqs++;
	task chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task rd(input logic [1:0] a, input logic [7:0] e);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b0;
		#1 chk(reg_rdata_o, e);
	endtask
	task t_regs;
		rd(2'h1, 8'h80);
		rd(2'h2, 8'h00);
		wr(2'h0, 8'hFF);
		rd(2'h0, 8'h00);
		wr(2'h1, 8'hFF);
		rd(2'h1, 8'h98);
		wr(2'h1, 8'h00);
		wr(2'h3, 8'hA4);
		rd(2'h3, 8'hA4);
	endtask
	task t_write;
		tw_master_inst.start();
		rd(2'h1, 8'hA0);
		tw_master_inst.xb(8'hA4, 1'b1, q, k);
		chk({7'h0, k}, 8'h00);
		chk(irqs[7:0], 8'h01);
		rd(2'h1, 8'hE0);
		chk({7'h0, scl_oe_n_o}, 8'h00);
		rd(2'h2, 8'h00);
		tw_master_inst.xb(8'hC5, 1'b1, q, k);
		chk({7'h0, k}, 8'h00);
		rd(2'h1, 8'hA0);
		rd(2'h2, 8'hC5);
		wr(2'h1, 8'h08);
		tw_master_inst.xb(8'h3A, 1'b1, q, k);
		chk({7'h0, k}, 8'h01);
		rd(2'h2, 8'h3A);
		tw_master_inst.stop();
		rd(2'h1, 8'h08);
	endtask
	task t_miss;
		tw_master_inst.start();
		tw_master_inst.xb(8'h20, 1'b1, q, k);
		chk({7'h0, k}, 8'h01);
		chk(irqs[7:0], 8'h03);
		tw_master_inst.stop();
	endtask
	task t_read;
		wr(2'h1, 8'h00);
		tw_master_inst.start();
		tw_master_inst.xb(8'hA5, 1'b1, q, k);
		rd(2'h1, 8'h64);
		wr(2'h1, 8'h10);
		wr(2'h2, 8'h96);
		tw_master_inst.xb(8'hFF, 1'b0, q, k);
		chk(q, 8'h96);
		rd(2'h1, 8'hB4);
		wr(2'h2, 8'h5B);
		tw_master_inst.xb(8'hFF, 1'b1, q, k);
		chk(q, 8'h5B);
		chk({6'h0, scl_oe_n_o, sda_oe_n_o}, 8'h03);
		tw_master_inst.stop();
		rd(2'h1, 8'h95);
	endtask
	task report_and_stop;
		$display("errors %0d checks %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge ref_clk_i);
		arst_n_i <= 1'b1;
		t_regs();
		t_write();
		t_miss();
		t_read();
		report_and_stop();
	end
	// whole run is some 12 us
	initial begin
		#200000;
		error_cnt++;
		report_and_stop();
	end
endmodule
